// >>> scaling_pkg.sv
package scaling_pkg;
    // ------------------------------------------------------------
    // register map (byte offsets)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_RANGE_LOW = 8'h04;
    localparam logic [7:0] ADDR_RANGE_HIGH = 8'h08;
    localparam logic [7:0] ADDR_IN_MARGIN = 8'h0C;
    localparam logic [7:0] ADDR_OUT_MARGIN = 8'h10;
    localparam logic [7:0] ADDR_SPAN_LOW = 8'h14;
    localparam logic [7:0] ADDR_SPAN_HIGH = 8'h18;
    localparam logic [7:0] ADDR_STATUS = 8'h1C;
    localparam logic [7:0] ADDR_DISPLAY = 8'h20;
    localparam logic [7:0] ADDR_SETPOINT = 8'h24;
    localparam logic [7:0] ADDR_POINT_BASE = 8'h40;
    localparam logic [7:0] ADDR_POINT_END = 8'h90;
    localparam logic [2:0] SIZE_WORD = 3'h2;

    // control register fields
    localparam int CTRL_RANGE_BIT = 0;
    localparam int CTRL_MODE_LSB = 1;
    localparam int CTRL_NPTS_LSB = 4;

    // ------------------------------------------------------------
    // characteristics and sequencer states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CHAR_LINEAR = 2'b00,
        CHAR_SQUARE = 2'b01,
        CHAR_ROOT = 2'b10,
        CHAR_USER = 2'b11
    } char_mode_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_NORM_WAIT = 4'b0001,
        ST_SQRT = 4'b0010,
        ST_SCALE = 4'b0011,
        ST_SEG_WAIT = 4'b0100,
        ST_OUT_WAIT = 4'b0101
    } calc_state_t;

    // ------------------------------------------------------------
    // fixed point: currents in 1/256 mA, normalised value Q16
    // ------------------------------------------------------------
    localparam logic signed [31:0] CUR_ZERO = 32'sh0000_0000;
    localparam logic signed [31:0] CUR_4MA = 32'sh0000_0400;
    localparam logic signed [31:0] CUR_20MA = 32'sh0000_1400;
    localparam logic signed [31:0] WIDTH_16MA = 32'sh0000_1000;
    localparam logic signed [31:0] WIDTH_20MA = 32'sh0000_1400;
    localparam logic signed [31:0] PERMILLE = 32'sh0000_03E8;
    localparam logic signed [31:0] ONE_Q16 = 32'sh0001_0000;
    localparam logic signed [63:0] HALF_Q16 = 64'sh0000_0000_0000_8000;
    localparam logic signed [63:0] DISP_MAX = 64'sh0000_0000_0000_7FFF;
    localparam logic signed [63:0] DISP_MIN = 64'shFFFF_FFFF_FFFF_8000;
    localparam int FRAC_BITS = 16;

    // table size, iteration counts, reset values
    localparam int MAX_POINTS = 20;
    localparam logic [4:0] MIN_NPTS = 5'h02;
    localparam logic [4:0] MAX_NPTS = 5'h14;
    localparam logic [5:0] DIV_STEPS = 6'h30;
    localparam logic [4:0] ROOT_TOP = 5'h17;
    localparam logic signed [15:0] RST_RANGE_HIGH = 16'sh03E8;
    localparam logic signed [15:0] RST_SPAN_HIGH = 16'sh03E8;
endpackage : scaling_pkg

// >>> seq_divider.sv
`timescale 1ns/10ps
module seq_divider import scaling_pkg::*; (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic start,
    input wire logic signed [47:0] num,
    input wire logic signed [31:0] den,
    output logic done,
    output logic signed [47:0] quot
);
    // ------------------------------------------------------------
    // restoring divider on magnitudes, one quotient bit per clock
    // ------------------------------------------------------------
    typedef struct packed {
        logic busy;
        logic neg;
        logic [5:0] cnt;
        logic [32:0] rem;
        logic [47:0] q;
        logic [31:0] d;
        logic done;
        logic signed [47:0] quot;
    } div_t;

    div_t c;
    div_t n;
    logic [32:0] r2;

    // one shift/subtract step, sign restored at the end
    always_comb begin
        n = c;
        n.done = 1'b0;
        r2 = {c.rem[31:0], c.q[47]};
        if (start) begin
            n.busy = 1'b1;
            n.neg = num[47] ^ den[31];
            n.q = num[47] ? 48'(-num) : 48'(num);
            n.d = den[31] ? 32'(-den) : 32'(den);
            n.rem = '0;
            n.cnt = DIV_STEPS;
        end else if (c.busy) begin
            n.q = {c.q[46:0], 1'b0};
            n.rem = r2;
            if (r2 >= {1'b0, c.d}) begin
                n.rem = r2 - {1'b0, c.d};
                n.q[0] = 1'b1;
            end
            n.cnt = c.cnt - 6'h01;
            if (c.cnt == 6'h01) begin
                n.busy = 1'b0;
                n.done = 1'b1;
                if (c.d == '0) begin
                    n.quot = '0; // zero span gives zero, never a hang
                end else begin
                    n.quot = c.neg ? -signed'(n.q) : signed'(n.q);
                end
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            c <= '0;
        end else begin
            c <= n;
        end
    end

    assign done = c.done;
    assign quot = c.quot;
endmodule : seq_divider

// >>> scaling_datapath.sv
`timescale 1ns/10ps
// What this block does
// - subtract range start: 0 or 4 mA
// - divide by range width: 20 or 16 mA
// - no clamping of normalised value
// - linear: norm times span plus low
// - low above high inverts the characteristic
// - square: square norm, then linear scaling
// - root: root of norm, then linear scaling
// - root of negative norm yields low exactly
// - user table of 2 to 20 points
// - interpolate inside selected segment, norm times 1000
// - extrapolate with outermost segment outside table
// - permissible borders widened by margin percentages
// - output is 4 mA plus 16 mA share
// - output clamped at violated working border
module scaling_datapath import scaling_pkg::*; (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic sample_valid,
    input wire logic [15:0] sample_current,
    output logic sample_ready,
    output logic result_valid,
    output logic signed [15:0] display_value,
    output logic [15:0] output_setpoint,
    output logic input_below_range,
    output logic input_above_range
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        calc_state_t st;
        logic range_4_20;
        char_mode_t mode;
        logic [4:0] npts;
        logic signed [15:0] lo;
        logic signed [15:0] hi;
        logic signed [15:0] spl;
        logic signed [15:0] sph;
        logic [15:0] in_lom;
        logic [15:0] in_him;
        logic [15:0] out_lom;
        logic [15:0] out_him;
        logic [MAX_POINTS-1:0][15:0] px;
        logic [MAX_POINTS-1:0][15:0] py;
        logic [15:0] cur;
        logic signed [31:0] nrm;
        logic signed [31:0] f;
        logic [23:0] root;
        logic [4:0] bitn;
        logic [4:0] seg;
        logic signed [15:0] disp;
        logic [15:0] outv;
        logic below;
        logic above;
        logic rvalid;
        logic div_go;
        logic signed [47:0] div_num;
        logic signed [31:0] div_den;
        logic dph;
        logic dph_write;
        logic [7:0] dph_addr;
    } core_t;

    core_t c;
    core_t n;
    logic div_done;
    logic signed [47:0] div_quot;
    logic signed [31:0] qn;
    logic signed [31:0] xn;
    logic [4:0] k;
    logic [4:0] k1;
    logic signed [63:0] seg_num;
    logic signed [31:0] seg_den;
    logic signed [15:0] disp_lin;
    logic signed [15:0] disp_seg;
    logic signed [15:0] disp_pick;
    logic signed [31:0] out_lo_b;
    logic signed [31:0] out_hi_b;
    logic signed [63:0] out_raw;
    logic [23:0] trial;
    logic [23:0] root_n;
    logic signed [31:0] start_cur;
    logic signed [31:0] diff;
    logic [31:0] rd;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic point_hit(input logic [7:0] a);
        return (a >= ADDR_POINT_BASE) && (a < ADDR_POINT_END);
    endfunction : point_hit

    function automatic logic [4:0] point_idx(input logic [7:0] a);
        logic [7:0] off;
        off = a - ADDR_POINT_BASE;
        return off[6:2];
    endfunction : point_idx

    function automatic logic signed [15:0] sat16(input logic signed [63:0] v);
        if (v > DISP_MAX) begin
            return DISP_MAX[15:0];
        end else if (v < DISP_MIN) begin
            return DISP_MIN[15:0];
        end
        return v[15:0];
    endfunction : sat16

    // border = base -/+ base * margin, margin in tenths of a percent
    function automatic logic signed [31:0] border(input logic signed [31:0] base,
                                                  input logic [15:0] m, input logic up);
        logic signed [31:0] d;
        d = (base * signed'({16'h0000, m})) / PERMILLE;
        return up ? base + d : base - d;
    endfunction : border

    seq_divider u_div (
        .hclk(hclk),
        .hresetn(hresetn),
        .start(c.div_go),
        .num(c.div_num),
        .den(c.div_den),
        .done(div_done),
        .quot(div_quot)
    );

    // ------------------------------------------------------------
    // arithmetic shared by the sequencer
    // ------------------------------------------------------------
    always_comb begin
        qn = div_quot[31:0];
        start_cur = c.range_4_20 ? CUR_4MA : CUR_ZERO;
        diff = signed'({16'h0000, sample_current}) - start_cur;
        xn = 32'((64'(qn) * 64'(PERMILLE)) >>> FRAC_BITS);
        // last segment whose lower point is at or below the input
        k = '0;
        for (int i = 1; i < MAX_POINTS - 1; i++) begin
            if ((i + int'(MIN_NPTS) <= int'(c.npts)) &&
                (signed'(c.px[i]) <= xn)) begin
                k = 5'(i);
            end
        end
        k1 = k + 5'h01;
        // (norm - X_low) * dY / dX, X in tenths of percent
        seg_num = (64'(qn) * 64'(PERMILLE) - (64'(signed'(c.px[k])) <<< FRAC_BITS))
                  * (64'(signed'(c.py[k1])) - 64'(signed'(c.py[k])));
        seg_den = 32'((64'(signed'(c.px[k1])) - 64'(signed'(c.px[k]))) <<< FRAC_BITS);
        disp_lin = sat16((((64'(c.f) * (64'(c.hi) - 64'(c.lo))) + HALF_Q16) >>> FRAC_BITS)
                         + 64'(c.lo));
        disp_seg = sat16(64'(div_quot) + 64'(signed'(c.py[c.seg])));
        disp_pick = (c.st == ST_SEG_WAIT) ? disp_seg : disp_lin;
        out_lo_b = border(CUR_4MA, c.out_lom, 1'b0);
        out_hi_b = border(CUR_20MA, c.out_him, 1'b1);
        out_raw = 64'(div_quot) + 64'(CUR_4MA);
        trial = c.root | (24'h00_0001 << c.bitn);
        root_n = ((48'(trial) * 48'(trial)) <= (48'(unsigned'(c.nrm)) << FRAC_BITS))
                 ? trial : c.root;
    end

    // ------------------------------------------------------------
    // register read mux (data phase address)
    // ------------------------------------------------------------
    always_comb begin
        rd = '0;
        if (c.dph_addr == ADDR_CTRL) begin
            rd = {23'h0, c.npts, 1'b0, c.mode, c.range_4_20};
        end else if (c.dph_addr == ADDR_RANGE_LOW) begin
            rd = 32'(c.lo);
        end else if (c.dph_addr == ADDR_RANGE_HIGH) begin
            rd = 32'(c.hi);
        end else if (c.dph_addr == ADDR_IN_MARGIN) begin
            rd = {c.in_him, c.in_lom};
        end else if (c.dph_addr == ADDR_OUT_MARGIN) begin
            rd = {c.out_him, c.out_lom};
        end else if (c.dph_addr == ADDR_SPAN_LOW) begin
            rd = 32'(c.spl);
        end else if (c.dph_addr == ADDR_SPAN_HIGH) begin
            rd = 32'(c.sph);
        end else if (c.dph_addr == ADDR_STATUS) begin
            rd = {29'h0, c.above, c.below, (c.st != ST_IDLE)};
        end else if (c.dph_addr == ADDR_DISPLAY) begin
            rd = 32'(c.disp);
        end else if (c.dph_addr == ADDR_SETPOINT) begin
            rd = {16'h0000, c.outv};
        end else if (point_hit(c.dph_addr)) begin
            rd = {c.py[point_idx(c.dph_addr)], c.px[point_idx(c.dph_addr)]};
        end
    end

    // ------------------------------------------------------------
    // next state: bus slave and sequencer
    // ------------------------------------------------------------
    always_comb begin
        n = c;
        n.rvalid = 1'b0;
        n.div_go = 1'b0;
        // address phase capture, zero wait states
        n.dph = hsel && hready && htrans[1];
        n.dph_write = hwrite && (hsize == SIZE_WORD);
        n.dph_addr = haddr[7:0];
        // register writes in the data phase
        if (c.dph && c.dph_write) begin
            if (c.dph_addr == ADDR_CTRL) begin
                n.range_4_20 = hwdata[CTRL_RANGE_BIT];
                n.mode = char_mode_t'(hwdata[CTRL_MODE_LSB +: 2]);
                n.npts = hwdata[CTRL_NPTS_LSB +: 5];
                if (n.npts < MIN_NPTS) begin
                    n.npts = MIN_NPTS;
                end else if (n.npts > MAX_NPTS) begin
                    n.npts = MAX_NPTS;
                end
            end else if (c.dph_addr == ADDR_RANGE_LOW) begin
                n.lo = hwdata[15:0];
            end else if (c.dph_addr == ADDR_RANGE_HIGH) begin
                n.hi = hwdata[15:0];
            end else if (c.dph_addr == ADDR_IN_MARGIN) begin
                n.in_lom = hwdata[15:0];
                n.in_him = hwdata[31:16];
            end else if (c.dph_addr == ADDR_OUT_MARGIN) begin
                n.out_lom = hwdata[15:0];
                n.out_him = hwdata[31:16];
            end else if (c.dph_addr == ADDR_SPAN_LOW) begin
                n.spl = hwdata[15:0];
            end else if (c.dph_addr == ADDR_SPAN_HIGH) begin
                n.sph = hwdata[15:0];
            end else if (point_hit(c.dph_addr)) begin
                n.px[point_idx(c.dph_addr)] = hwdata[15:0];
                n.py[point_idx(c.dph_addr)] = hwdata[31:16];
            end
        end
        // computation sequencer
        case (c.st)
            ST_IDLE: begin
                if (sample_valid) begin
                    n.cur = sample_current;
                    n.below = signed'({16'h0000, sample_current}) <
                              border(start_cur, c.in_lom, 1'b0);
                    n.above = signed'({16'h0000, sample_current}) >
                              border(CUR_20MA, c.in_him, 1'b1);
                    n.div_go = 1'b1;
                    n.div_num = 48'(64'(diff) <<< FRAC_BITS);
                    n.div_den = c.range_4_20 ? WIDTH_16MA : WIDTH_20MA;
                    n.st = ST_NORM_WAIT;
                end
            end
            ST_NORM_WAIT: begin
                if (div_done) begin
                    n.nrm = qn;
                    case (c.mode)
                        CHAR_LINEAR: begin
                            n.f = qn;
                            n.st = ST_SCALE;
                        end
                        CHAR_SQUARE: begin
                            n.f = 32'((64'(qn) * 64'(qn)) >>> FRAC_BITS);
                            n.st = ST_SCALE;
                        end
                        CHAR_ROOT: begin
                            if (qn < 0) begin
                                n.f = '0;
                                n.st = ST_SCALE;
                            end else begin
                                n.root = '0;
                                n.bitn = ROOT_TOP;
                                n.st = ST_SQRT;
                            end
                        end
                        default: begin
                            n.seg = k;
                            n.div_go = 1'b1;
                            n.div_num = 48'(seg_num);
                            n.div_den = seg_den;
                            n.st = ST_SEG_WAIT;
                        end
                    endcase
                end
            end
            ST_SQRT: begin
                n.root = root_n;
                n.bitn = c.bitn - 5'h01;
                if (c.bitn == '0) begin
                    n.f = signed'({8'h00, root_n});
                    n.st = ST_SCALE;
                end
            end
            ST_SCALE, ST_SEG_WAIT: begin
                if ((c.st == ST_SCALE) || div_done) begin
                    n.disp = disp_pick;
                    n.div_go = 1'b1;
                    n.div_num = 48'((64'(disp_pick) - 64'(c.spl)) * 64'(WIDTH_16MA));
                    n.div_den = 32'(64'(c.sph) - 64'(c.spl));
                    n.st = ST_OUT_WAIT;
                end
            end
            ST_OUT_WAIT: begin
                if (div_done) begin
                    if (out_raw > 64'(out_hi_b)) begin
                        n.outv = out_hi_b[15:0];
                    end else if (out_raw < 64'(out_lo_b)) begin
                        n.outv = out_lo_b[15:0];
                    end else begin
                        n.outv = out_raw[15:0];
                    end
                    n.rvalid = 1'b1;
                    n.st = ST_IDLE;
                end
            end
            default: begin
                n.st = ST_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            c <= '{st: ST_IDLE, mode: CHAR_LINEAR, range_4_20: 1'b1, npts: MIN_NPTS,
                   hi: RST_RANGE_HIGH, sph: RST_SPAN_HIGH, default: '0};
        end else begin
            c <= n;
        end
    end

    // outputs
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rd;
    assign sample_ready = (c.st == ST_IDLE);
    assign result_valid = c.rvalid;
    assign display_value = c.disp;
    assign output_setpoint = c.outv;
    assign input_below_range = c.below;
    assign input_above_range = c.above;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    norm_offset_a: assert property (c.rvalid |->
        ((c.nrm == 0) == (signed'({16'h0000, c.cur}) == start_cur)))
        else $error("zero norm not tied to range start");
    norm_width_a: assert property (c.rvalid && (signed'({16'h0000, c.cur}) == CUR_20MA)
        |-> c.nrm == ONE_Q16)
        else $error("full scale input not normalised to one");
    no_clamp_a: assert property (c.rvalid && (signed'({16'h0000, c.cur}) < start_cur)
        |-> c.nrm < 0)
        else $error("under range norm was clamped");
    lin_ends_a: assert property (c.rvalid && (c.mode == CHAR_LINEAR) && (c.nrm == ONE_Q16)
        |-> c.disp == c.hi)
        else $error("linear full scale differs from high value");
    square_ends_a: assert property (c.rvalid && (c.mode == CHAR_SQUARE) && (c.nrm == ONE_Q16)
        |-> c.disp == c.hi)
        else $error("square full scale differs from high value");
    root_neg_a: assert property (c.rvalid && (c.mode == CHAR_ROOT) && (c.nrm < 0)
        |-> c.disp == c.lo)
        else $error("negative root input not at low value");
    npts_bound_a: assert property ((c.npts >= MIN_NPTS) && (c.npts <= MAX_NPTS))
        else $error("point count outside table limits");
    out_clamp_a: assert property ($rose(c.rvalid) |->
        (signed'({16'h0000, c.outv}) <= out_hi_b) && (signed'({16'h0000, c.outv}) >= out_lo_b))
        else $error("setpoint outside working range");
    done_time_a: assert property (sample_valid && sample_ready |->
        ##[1:200] result_valid)
        else $error("result not delivered in time");
endmodule : scaling_datapath

// >>> front_end_model.sv
`timescale 1ns/10ps
module front_end_model (
    input wire logic hclk,
    input wire logic sample_ready,
    output logic sample_valid,
    output logic [15:0] sample_current
);
    // idle front end: no strobe, line shows nothing useful
    initial begin
        sample_valid = 1'b0;
        sample_current = 16'h0000;
    end

    // offer one sample, hold it until taken, then release the line
    task automatic send(input logic [15:0] cur, input int gap);
        repeat (gap) @(posedge hclk);
        sample_valid <= 1'b1;
        sample_current <= cur;
        do @(posedge hclk); while (sample_ready !== 1'b1);
        sample_valid <= 1'b0;
        sample_current <= ~cur; // released line no longer shows the sample
    endtask : send
endmodule : front_end_model

// >>> meter_value_scaling_datapath_test.sv
`timescale 1ns/10ps
module meter_value_scaling_datapath_test import scaling_pkg::*;;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic hready, hresp, sample_valid, sample_ready, result_valid, below, above;
    logic [31:0] hrdata, rd;
    logic [15:0] sample_current, output_setpoint;
    logic signed [15:0] display_value;
    int bad_count = 0;
    int samples_checked = 0;

    // ----------------------------------------
    // clock, design and front end
    // ----------------------------------------
    always #12.5 hclk = ~hclk;

    scaling_datapath dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .sample_valid(sample_valid),
        .sample_current(sample_current), .sample_ready(sample_ready),
        .result_valid(result_valid), .display_value(display_value),
        .output_setpoint(output_setpoint), .input_below_range(below),
        .input_above_range(above));

    front_end_model fe (.hclk(hclk), .sample_ready(sample_ready),
        .sample_valid(sample_valid), .sample_current(sample_current));

    // ----------------------------------------
    // bus cycles and comparison
    // ----------------------------------------
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d);
        haddr <= {24'h00_0000, a};
        htrans <= 2'b10;
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
        check("hresp", 32'h0000_0000, {31'h0, hresp}); // bus answer is always okay
    endtask : bus

    // set up one sample, wait for its result, compare everything
    task automatic run_case(input logic [7:0] ctrl, input logic [15:0] lo, input logic [15:0] hi,
            input logic [15:0] cur, input logic [15:0] ed, input logic [15:0] es,
            input logic eb, input logic ea);
        int n;
        bus(ADDR_CTRL, 1'b1, {24'h00_0000, ctrl});
        bus(ADDR_RANGE_LOW, 1'b1, {{16{lo[15]}}, lo});
        bus(ADDR_RANGE_HIGH, 1'b1, {{16{hi[15]}}, hi});
        fe.send(cur, ctrl[2] ? 3 : 0);
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (result_valid !== 1'b1 && n < 300);
        check("result_valid", 32'h0000_0001, {31'h0, result_valid});
        check("display", {16'h0000, ed}, {16'h0000, display_value});
        check("setpoint", {16'h0000, es}, {16'h0000, output_setpoint});
        check("flags", {30'h0, eb, ea}, {30'h0, below, above});
        check("ready", 32'h0000_0001, {31'h0, sample_ready});
        // the same results as seen through the register bus
        bus(ADDR_STATUS, 1'b0, 32'h0000_0000);
        check("status", {29'h0, ea, eb, 1'b0}, rd);
        bus(ADDR_DISPLAY, 1'b0, 32'h0000_0000);
        check("display reg", {{16{ed[15]}}, ed}, rd);
        bus(ADDR_SETPOINT, 1'b0, 32'h0000_0000);
        check("setpoint reg", {16'h0000, es}, rd);
    endtask : run_case

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : tally_and_finish

    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        bus(ADDR_CTRL, 1'b0, 32'h0000_0000);
        check("ctrl reset", 32'h0000_0021, rd);
        bus(ADDR_RANGE_HIGH, 1'b0, 32'h0000_0000);
        check("high reset", 32'h0000_03e8, rd);
        bus(8'h30, 1'b0, 32'h0000_0000);
        check("unmapped", 32'h0000_0000, rd);
        bus(ADDR_CTRL, 1'b1, 32'h0000_01f1);
        bus(ADDR_CTRL, 1'b0, 32'h0000_0000);
        check("ctrl clamp", 32'h0000_0141, rd);
        bus(ADDR_IN_MARGIN, 1'b1, 32'h0064_00c8);
        bus(ADDR_OUT_MARGIN, 1'b1, 32'h0064_00fa);
        bus(ADDR_SPAN_HIGH, 1'b1, 32'h0000_0640);
        bus(ADDR_POINT_BASE + 8'h04, 1'b1, 32'h0064_01f4);
        bus(ADDR_POINT_BASE + 8'h08, 1'b1, 32'h012c_03e8);
        bus(ADDR_SPAN_HIGH, 1'b0, 32'h0000_0000);
        check("span high", 32'h0000_0640, rd);
        run_case(8'h31, 16'hfed4, 16'h0514, 16'h0a00, 16'h012c, 16'h0700, 0, 0);
        run_case(8'h31, 16'hfed4, 16'h0514, 16'h0200, 16'hfe0c, 16'h0300, 1, 0);
        run_case(8'h31, 16'hfed4, 16'h0514, 16'h1700, 16'h0640, 16'h1400, 0, 1);
        run_case(8'h31, 16'h0514, 16'hfed4, 16'h0a00, 16'h02bc, 16'h0b00, 0, 0);
        run_case(8'h30, 16'h0000, 16'h03e8, 16'h0500, 16'h00fa, 16'h0680, 0, 0);
        run_case(8'h33, 16'hfed4, 16'h0514, 16'h0c00, 16'h0064, 16'h0500, 0, 0);
        run_case(8'h35, 16'hfed4, 16'h0514, 16'h0800, 16'h01f4, 16'h0900, 0, 0);
        run_case(8'h35, 16'hfed4, 16'h0514, 16'h0200, 16'hfed4, 16'h0300, 1, 0);
        run_case(8'h37, 16'h0000, 16'h0000, 16'h0a00, 16'h004b, 16'h04c0, 0, 0);
        run_case(8'h37, 16'h0000, 16'h0000, 16'h1000, 16'h00c8, 16'h0600, 0, 0);
        run_case(8'h37, 16'h0000, 16'h0000, 16'h1600, 16'h015e, 16'h0780, 0, 0);
        run_case(8'h37, 16'h0000, 16'h0000, 16'h0200, 16'hffe7, 16'h03c0, 1, 0);
        run_case(8'h30, 16'h0000, 16'h0bb8, 16'h1400, 16'h0bb8, 16'h1600, 0, 0);
        run_case(8'h33, 16'hfed4, 16'h0514, 16'h1400, 16'h0514, 16'h1100, 0, 0);
        bus(ADDR_SPAN_LOW, 1'b1, 32'h0000_0190);
        run_case(8'h30, 16'h0000, 16'h03e8, 16'h0a00, 16'h01f4, 16'h0555, 0, 0);
        tally_and_finish();
    end

    // watchdog against a hung handshake
    initial begin
        #500000;
        bad_count++;
        tally_and_finish();
    end
endmodule : meter_value_scaling_datapath_test
